// >>> cbsu_consts.vh
// constants for the conditional branch and skip unit
// Functional notes
// - compare subtracts immediate, sets flags, one cycle
// - skip when register bit clear, pc+2/3
// - skip when register bit set, pc+2/3
// - skip when io bit clear, pc+2/3
// - skip when io bit set, pc+2/3
// - branch when selected flag set, pc+k+1
// - branch when selected flag clear, pc+k+1
// - equal on zero set, not-equal on clear
// - carry set and carry clear branches
// - same-or-higher on carry clear, lower on set
// - minus on negative set, plus on clear
// - signed ge when negative xor overflow zero
// - signed lt when negative xor overflow one
// - half-carry set branch taken on half-carry one
// - half-carry clear branch taken on zero
`ifndef CBSU_CONSTS_VH
`define CBSU_CONSTS_VH

// register byte offsets
`define OFS_CTRL   8'h00
`define OFS_OPND   8'h04
`define OFS_STATUS_REGISTER   8'h08
`define OFS_PC     8'h0C
`define OFS_STAT   8'h10

// control field positions
`define CTRL_OP_HI  4
`define CTRL_OP_LO  0
`define CTRL_BIT_HI 7
`define CTRL_BIT_LO 5
`define CTRL_LONG   8

// operand field positions
`define OPND_WR_HI  7
`define OPND_WR_LO  0
`define OPND_IO_HI  15
`define OPND_IO_LO  8
`define OPND_IMM_HI 23
`define OPND_IMM_LO 16
`define OPND_K_HI   30
`define OPND_K_LO   24

// status_register bit positions
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7

// operation codes
`define OP_COMPARE_IMM         5'h00
`define OP_SKIP_REG_BIT_CLEAR  5'h01
`define OP_SKIP_REG_BIT_SET    5'h02
`define OP_SKIP_IO_BIT_CLEAR   5'h03
`define OP_SKIP_IO_BIT_SET     5'h04
`define OP_BR_SEL_FLAG_SET     5'h05
`define OP_BR_SEL_FLAG_CLEAR   5'h06
`define OP_BR_EQUAL            5'h07
`define OP_BR_NOT_EQUAL        5'h08
`define OP_BR_CARRY_SET        5'h09
`define OP_BR_CARRY_CLEAR      5'h0A
`define OP_BR_UNS_HIGHER_SAME  5'h0B
`define OP_BR_UNS_LOWER        5'h0C
`define OP_BR_NEGATIVE         5'h0D
`define OP_BR_POSITIVE         5'h0E
`define OP_BR_SIGNED_GE        5'h0F
`define OP_BR_SIGNED_LT        5'h10
`define OP_BR_HALF_CARRY_SET   5'h11
`define OP_BR_HALF_CARRY_CLEAR 5'h12
`define OP_BR_TRANSFER_SET     5'h13

// cycle counts and pc steps
`define CYC_ONE        2'h1
`define CYC_TWO        2'h2
`define CYC_THREE      2'h3
`define PC_STEP_NEXT   16'h0001
`define PC_STEP_SKIP1  16'h0002
`define PC_STEP_SKIP2  16'h0003

// reset values
`define RST_CTRL  9'h000
`define RST_OPND  31'h00000000
`define RST_STATUS_REGISTER  8'h00
`define RST_PC    16'h0000
`define RST_CYC   2'h0
`define RST_RDATA 32'h00000000

// bit positions used by the compare and the bus slices
`define BYTE_MSB   7
`define NIBBLE_MSB 3
`define STATUS_REGISTER_MSB   7
`define PC_MSB     15
`define DATA_LSB   0

`endif

// >>> cond_branch_skip_unit.v
// conditional branch, skip and compare unit with apb register port
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
`include "cbsu_consts.vh"

module cond_branch_skip_unit (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        busy
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg        state_r;
	reg        state_nxt;
	reg  [1:0] cnt_r;
	reg  [1:0] cnt_nxt;
	reg  [8:0] ctrl_r;
	reg [30:0] opnd_r;
	reg  [7:0] status_register_r;
	reg  [7:0] status_register_nxt;
	reg [15:0] pc_r;
	reg        taken_r;
	reg  [1:0] last_cyc_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;

	wire        acc_en;
	wire        wr_en;
	wire        mapped;
	wire        refused;
	wire  [4:0] op;
	wire  [2:0] bsel;
	wire        long_next;
	wire  [7:0] wr_val;
	wire  [7:0] io_val;
	wire  [7:0] imm;
	wire  [6:0] k_off;
	wire  [7:0] diff;
	wire        wr_ctrl;
	wire        wr_opnd;
	wire        wr_status_register;
	wire        wr_pc;
	wire        rd_setup;
	wire        commit;
	wire        cmp_z;
	wire        cmp_n;
	wire        cmp_v;
	wire        cmp_c;
	wire        cmp_h;
	wire [15:0] pc_seq;
	wire [15:0] pc_skip_short;
	wire [15:0] pc_skip_long;
	wire [15:0] pc_branch;

	reg        is_skip;
	reg        is_branch;
	reg        cond;
	reg  [1:0] cyc;
	reg [15:0] pc_new;
	wire       last_cyc;

	// sign-extend the 7-bit branch displacement
	function [15:0] sext_k;
		input [6:0] k;
		begin
			sext_k = {{9{k[6]}}, k};
		end
	endfunction

	// pick one bit of a byte
	function bit_of;
		input [7:0] v;
		input [2:0] b;
		begin
			bit_of = v[b];
		end
	endfunction

	// borrow out of one bit of a subtraction, shared by carry and half-carry
	function borrow_of;
		input a;
		input b;
		input r;
		begin
			borrow_of = (~a & b) | (b & r) | (r & ~a);
		end
	endfunction

	assign op        = ctrl_r[`CTRL_OP_HI:`CTRL_OP_LO];
	assign bsel      = ctrl_r[`CTRL_BIT_HI:`CTRL_BIT_LO];
	assign long_next = ctrl_r[`CTRL_LONG];
	assign wr_val    = opnd_r[`OPND_WR_HI:`OPND_WR_LO];
	assign io_val    = opnd_r[`OPND_IO_HI:`OPND_IO_LO];
	assign imm       = opnd_r[`OPND_IMM_HI:`OPND_IMM_LO];
	assign k_off     = opnd_r[`OPND_K_HI:`OPND_K_LO];
	assign diff      = wr_val - imm;

	assign busy = (state_r == ST_EXEC);

	// apb: zero wait states, answer in the access cycle
	assign pready = 1'b1;
	assign acc_en = psel & penable;
	assign mapped = (paddr == `OFS_CTRL) | (paddr == `OFS_OPND) |
	                (paddr == `OFS_STATUS_REGISTER) | (paddr == `OFS_PC) |
	                (paddr == `OFS_STAT);
	// operands must not move under a running operation
	assign refused = pwrite & busy & (paddr != `OFS_STAT);
	assign pslverr = acc_en & (~mapped | refused);
	assign wr_en   = acc_en & pwrite & mapped & ~refused;
	assign prdata  = rdata_r;

	assign wr_ctrl  = wr_en & (paddr == `OFS_CTRL);
	assign wr_opnd  = wr_en & (paddr == `OFS_OPND);
	assign wr_status_register  = wr_en & (paddr == `OFS_STATUS_REGISTER);
	assign wr_pc    = wr_en & (paddr == `OFS_PC);
	assign rd_setup = psel & ~penable & ~pwrite;

	// candidate targets; all of them wrap silently at the top of the space
	assign pc_seq        = pc_r + `PC_STEP_NEXT;
	assign pc_skip_short = pc_r + `PC_STEP_SKIP1;
	assign pc_skip_long  = pc_r + `PC_STEP_SKIP2;
	assign pc_branch     = pc_r + sext_k(k_off) + `PC_STEP_NEXT;

	// condition evaluation
	always @* begin
		is_skip   = 1'b0;
		is_branch = 1'b1;
		cond      = 1'b0;
		case (op)
		`OP_COMPARE_IMM: begin
			is_branch = 1'b0;
		end
		`OP_SKIP_REG_BIT_CLEAR: begin
			is_skip = 1'b1;
			cond    = ~bit_of(wr_val, bsel);
		end
		`OP_SKIP_REG_BIT_SET: begin
			is_skip = 1'b1;
			cond    = bit_of(wr_val, bsel);
		end
		`OP_SKIP_IO_BIT_CLEAR: begin
			is_skip = 1'b1;
			cond    = ~bit_of(io_val, bsel);
		end
		`OP_SKIP_IO_BIT_SET: begin
			is_skip = 1'b1;
			cond    = bit_of(io_val, bsel);
		end
		`OP_BR_SEL_FLAG_SET: begin
			cond = bit_of(status_register_r, bsel);
		end
		`OP_BR_SEL_FLAG_CLEAR: begin
			cond = ~bit_of(status_register_r, bsel);
		end
		`OP_BR_EQUAL: begin
			cond = status_register_r[`FLG_Z];
		end
		`OP_BR_NOT_EQUAL: begin
			cond = ~status_register_r[`FLG_Z];
		end
		`OP_BR_CARRY_SET: begin
			cond = status_register_r[`FLG_C];
		end
		`OP_BR_CARRY_CLEAR: begin
			cond = ~status_register_r[`FLG_C];
		end
		`OP_BR_UNS_HIGHER_SAME: begin
			cond = ~status_register_r[`FLG_C];
		end
		`OP_BR_UNS_LOWER: begin
			cond = status_register_r[`FLG_C];
		end
		`OP_BR_NEGATIVE: begin
			cond = status_register_r[`FLG_N];
		end
		`OP_BR_POSITIVE: begin
			cond = ~status_register_r[`FLG_N];
		end
		`OP_BR_SIGNED_GE: begin
			// stored sign flag is not trusted, recompute it
			cond = ~(status_register_r[`FLG_N] ^ status_register_r[`FLG_V]);
		end
		`OP_BR_SIGNED_LT: begin
			cond = status_register_r[`FLG_N] ^ status_register_r[`FLG_V];
		end
		`OP_BR_HALF_CARRY_SET: begin
			cond = status_register_r[`FLG_H];
		end
		`OP_BR_HALF_CARRY_CLEAR: begin
			cond = ~status_register_r[`FLG_H];
		end
		`OP_BR_TRANSFER_SET: begin
			cond = status_register_r[`FLG_T];
		end
		default: begin
			// unknown op acts as a one-cycle no-op
			is_branch = 1'b0;
		end
		endcase
	end

	// cycle count and next program counter
	always @* begin
		cyc    = `CYC_ONE;
		pc_new = pc_seq;
		if (is_skip && cond) begin
			if (long_next) begin
				cyc    = `CYC_THREE;
				pc_new = pc_skip_long;
			end else begin
				cyc    = `CYC_TWO;
				pc_new = pc_skip_short;
			end
		end else if (is_branch && !is_skip && cond) begin
			cyc    = `CYC_TWO;
			pc_new = pc_branch;
		end
	end

	// compare flags, worked out for every op but committed by the compare only
	assign cmp_z = (diff == 8'h00);
	assign cmp_n = diff[`BYTE_MSB];
	assign cmp_v = (wr_val[`BYTE_MSB] & ~imm[`BYTE_MSB] & ~diff[`BYTE_MSB]) |
	               (~wr_val[`BYTE_MSB] & imm[`BYTE_MSB] & diff[`BYTE_MSB]);
	assign cmp_c = borrow_of(wr_val[`BYTE_MSB], imm[`BYTE_MSB], diff[`BYTE_MSB]);
	assign cmp_h = borrow_of(wr_val[`NIBBLE_MSB], imm[`NIBBLE_MSB], diff[`NIBBLE_MSB]);

	// every other op leaves the flags alone
	always @* begin
		status_register_nxt = status_register_r;
		if (op == `OP_COMPARE_IMM) begin
			status_register_nxt[`FLG_Z] = cmp_z;
			status_register_nxt[`FLG_N] = cmp_n;
			status_register_nxt[`FLG_V] = cmp_v;
			status_register_nxt[`FLG_C] = cmp_c;
			status_register_nxt[`FLG_H] = cmp_h;
		end
	end

	assign last_cyc = (cnt_r == cyc - `CYC_ONE);
	assign commit   = busy & last_cyc;

	// sequencer
	always @* begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
		ST_IDLE: begin
			if (wr_ctrl) begin
				state_nxt = ST_EXEC;
				cnt_nxt   = `RST_CYC;
			end
		end
		ST_EXEC: begin
			if (last_cyc) begin
				state_nxt = ST_IDLE;
			end else begin
				cnt_nxt = cnt_r + `CYC_ONE;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cnt_r   <= `RST_CYC;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// operands only load while idle, so they stay put for the whole operation
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `RST_CTRL;
			opnd_r <= `RST_OPND;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= pwdata[`CTRL_LONG:`CTRL_OP_LO];
			end
			if (wr_opnd) begin
				opnd_r <= pwdata[`OPND_K_HI:`OPND_WR_LO];
			end
		end
	end

	// results commit in the final cycle and beat a software write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_register_r <= `RST_STATUS_REGISTER;
			pc_r              <= `RST_PC;
			taken_r           <= 1'b0;
			last_cyc_r        <= `RST_CYC;
		end else if (commit) begin
			pc_r              <= pc_new;
			status_register_r <= status_register_nxt;
			taken_r           <= cond & (is_skip | is_branch);
			last_cyc_r        <= cyc;
		end else begin
			if (wr_status_register) begin
				status_register_r <= pwdata[`STATUS_REGISTER_MSB:`DATA_LSB];
			end
			if (wr_pc) begin
				pc_r <= pwdata[`PC_MSB:`DATA_LSB];
			end
		end
	end

	// read multiplexer; unmapped offsets read zero
	always @* begin
		rdata_nxt = `RST_RDATA;
		case (paddr)
		`OFS_CTRL: rdata_nxt = {23'h000000, ctrl_r};
		`OFS_OPND: rdata_nxt = {1'b0, opnd_r};
		`OFS_STATUS_REGISTER: rdata_nxt = {24'h000000, status_register_r};
		`OFS_PC:   rdata_nxt = {16'h0000, pc_r};
		`OFS_STAT: rdata_nxt = {28'h0000000, last_cyc_r, taken_r, busy};
		default:   rdata_nxt = `RST_RDATA;
		endcase
	end

	// read data registered in the setup cycle so it stands for the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= `RST_RDATA;
		end else if (rd_setup) begin
			rdata_r <= rdata_nxt;
		end
	end

endmodule // cond_branch_skip_unit

`default_nettype wire

// >>> cbsu_chk.sv
// assertion checker for the branch and skip unit
`default_nettype none
`include "cbsu_consts.vh"
module cbsu_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       acc = psel & penable;
	wire       go  = acc & pwrite & (paddr == `OFS_CTRL) & !busy;
	wire [4:0] op  = pwdata[4:0];
	wire       skp = (op >= 5'h01) && (op <= 5'h04);
	a_cmp_one_cycle: assert property (go && op == 5'h00 |=> busy ##1 !busy)
		else $error("compare length wrong");
	a_skip_short: assert property (go && skp && !pwdata[8] |=> busy ##1 (!busy or (busy ##1 !busy)))
		else $error("short skip length wrong");
	a_skip_long: assert property (go && skp && pwdata[8] |=> busy ##1 (!busy or (busy[*2] ##1 !busy)))
		else $error("long skip length wrong");
	a_branch_len: assert property (go && op >= 5'h05 && op <= 5'h13 |=> busy ##1 (!busy or (busy ##1 !busy)))
		else $error("branch length wrong");
	a_unknown_op: assert property (go && op > 5'h13 |=> busy ##1 !busy)
		else $error("unknown op length wrong");
	a_busy_cause: assert property ($rose(busy) |-> $past(go))
		else $error("busy without start");
	a_busy_refuse: assert property (acc && pwrite && busy && paddr < 8'h10 && paddr[1:0] == 2'h0 |-> pslverr)
		else $error("write while busy accepted");
	a_unmapped_rd: assert property (acc && !pwrite && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read accepted");
endmodule // cbsu_chk
bind cond_branch_skip_unit cbsu_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// >>> tb_cond_branch_skip_unit.sv
// self-checking bench for the branch and skip unit
`default_nettype none
`include "cbsu_consts.vh"
module tb_cond_branch_skip_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         busy;
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [31:0] rd;
	logic        err;
	logic        t;
	logic [2:0]  b;
	logic [6:0]  k;
	logic [7:0]  s;
	logic [15:0] e;
	logic [1:0]  n;
	logic [7:0]  sv [3] = '{8'h00, 8'hFF, 8'h25};
	logic [31:0] cv [2] = '{32'h0020_0010, 32'h0001_0080};
	logic [7:0]  cs [2] = '{8'h40, 8'h10};
	logic [7:0]  ce [2] = '{8'h45, 8'h38};
	localparam logic [7:0] wv = 8'h5A;
	localparam logic [7:0] iv = 8'hA5;
	cond_branch_skip_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy));
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// one apb transfer; request held until pready seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// load operands, start, optionally poke pc while busy, poll until idle
	task automatic run(input logic [8:0] c, input logic [31:0] o, input logic [7:0] sr,
		input logic [15:0] p, input logic x);
		xfer(1'h1, `OFS_OPND, o);
		xfer(1'h1, `OFS_STATUS_REGISTER, {24'h0, sr});
		xfer(1'h1, `OFS_PC, {16'h0, p});
		xfer(1'h1, `OFS_CTRL, {23'h0, c});
		if (x) begin
			xfer(1'h1, `OFS_PC, 32'h1234);
			chk("busy write err", 32'h1, {31'h0, err});
		end
		rd = 32'h1;
		for (int i = 0; i < 8 && rd[0] !== 1'h0; i++) xfer(1'h0, `OFS_STAT, 32'h0);
	endtask
	function automatic logic tk(input logic [4:0] op, input logic [2:0] bi, input logic [7:0] f);
		case (op)
			5'h01: tk = ~wv[bi];
			5'h02: tk = wv[bi];
			5'h03: tk = ~iv[bi];
			5'h04: tk = iv[bi];
			5'h05: tk = f[bi];
			5'h06: tk = ~f[bi];
			5'h07: tk = f[1];
			5'h08: tk = ~f[1];
			5'h09, 5'h0C: tk = f[0];
			5'h0A, 5'h0B: tk = ~f[0];
			5'h0D: tk = f[2];
			5'h0E: tk = ~f[2];
			5'h0F: tk = ~(f[2] ^ f[3]);
			5'h10: tk = f[2] ^ f[3];
			5'h11: tk = f[5];
			5'h12: tk = ~f[5];
			5'h13: tk = f[6];
			default: tk = 1'h0;
		endcase
	endfunction
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		xfer(1'h0, `OFS_PC, 32'h0);
		chk("pc after reset", 32'h0, rd);
		xfer(1'h0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		for (int i = 0; i < 2; i++) begin
			run(9'h000, cv[i], cs[i], 16'h0100, 1'h0);
			chk("cmp stat", 32'h4, rd & 32'hF);
			xfer(1'h0, `OFS_STATUS_REGISTER, 32'h0);
			chk("cmp flags", {24'h0, ce[i]}, rd);
			xfer(1'h0, `OFS_PC, 32'h0);
			chk("cmp pc", 32'h0101, rd);
		end
		// every op but the compare, plus one unknown op, against clear, all-set and mixed flags; odd passes use long skips
		for (int op = 1; op < 21; op++)
			for (int j = 0; j < 3; j++) begin
				b = 3'(op + j);
				s = sv[j];
				k = j[0] ? 7'h40 : 7'h3F;
				t = (op < 20) ? tk(5'(op), b, s) : 1'h0;
				run({j[0], b, 5'(op == 20 ? 31 : op)}, {1'h0, k, 8'h00, iv, wv}, s, 16'h0010, 1'h0);
				if (op < 5) e = t ? 16'h0012 + j[0] : 16'h0011;
				else e = t ? 16'h0011 + {{9{k[6]}}, k} : 16'h0011;
				n = t ? ((op < 5) ? 2'h2 + j[0] : 2'h2) : 2'h1;
				chk("stat", {28'h0, n, t, 1'h0}, rd & 32'hF);
				xfer(1'h0, `OFS_PC, 32'h0);
				chk("pc", {16'h0, e}, rd);
				xfer(1'h0, `OFS_STATUS_REGISTER, 32'h0);
				chk("flags kept", {24'h0, s}, rd);
			end
		run(9'h162, {8'h00, 8'h00, iv, wv}, 8'h00, 16'h0010, 1'h1);
		xfer(1'h0, `OFS_PC, 32'h0);
		chk("pc after refused write", 32'h0013, rd);
		finish_test();
	end
endmodule // tb_cond_branch_skip_unit
`default_nettype wire
